// ---- hw/adcro_host.sv ----
// Host end: drives toggle and shift clock, collects frame
`timescale 1ns/10ps
module adcro_host #(
	parameter int GUARD_CYC = adcro_pkg::GUARD_CYC
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	adcro_if.host            lnk,
	input  wire logic        toggle_req,
	input  wire logic        long_words,
	output logic             bit_valid,
	output logic             bit_data,
	output logic             busy
);
	typedef enum logic [3:0] {
		ADCRO_IDLE  = 4'b0001,
		ADCRO_WAIT  = 4'b0010,
		ADCRO_SHIFT = 4'b0100,
		ADCRO_GUARD = 4'b1000
	} adcro_state_t;

	adcro_state_t state;
	logic [2:0]   rdy_sync;
	logic [15:0]  guard;
	logic [15:0]  quiet;
	logic [7:0]   bits;
	logic [1:0]   div;
	logic         sclk;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdy_sync <= 3'h7;
		end else begin
			rdy_sync <= {rdy_sync[1:0], lnk.data_ready_n};
		end
	end

	// Cycles since the shift clock last moved
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			quiet <= 16'(GUARD_CYC);
		end else if (state == ADCRO_SHIFT) begin
			quiet <= 16'h0000;
		end else if (quiet != 16'(GUARD_CYC)) begin
			quiet <= quiet + 16'h0001;
		end
	end

	// Guard counter restarts at every toggle edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			guard                     <= 16'h0000;
			lnk.integrate_side_toggle <= 1'b0;
		end else if (toggle_req && state != ADCRO_SHIFT && quiet == 16'(GUARD_CYC)) begin
			lnk.integrate_side_toggle <= ~lnk.integrate_side_toggle;
			guard                     <= 16'(GUARD_CYC);
		end else if (guard != 16'h0000) begin
			guard <= guard - 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= ADCRO_IDLE;
			bits  <= 8'h00;
			div   <= 2'h0;
			sclk  <= 1'b1;
			bit_valid <= 1'b0;
			bit_data  <= 1'b0;
		end else begin
			bit_valid <= 1'b0;
			case (state)
				ADCRO_IDLE: begin
					if (rdy_sync[2] == rdy_sync[1] && !rdy_sync[2]) begin
						state <= ADCRO_WAIT;
					end
				end
				ADCRO_WAIT: begin
					if (guard == 16'h0000 && !toggle_req) begin
						state <= ADCRO_SHIFT;
						bits  <= long_words ? 8'(adcro_pkg::FRAME_LONG)
						                    : 8'(adcro_pkg::FRAME_SHORT);
					end
				end
				ADCRO_SHIFT: begin
					div <= div + 2'h1;
					if (div == 2'h1) begin
						sclk <= 1'b1;
						if (bits == 8'h00) begin
							state <= ADCRO_GUARD;
						end
					end else if (div == 2'h3) begin
						sclk      <= 1'b0;
						bit_valid <= 1'b1;
						bit_data  <= lnk.serial_out;
						bits      <= bits - 8'h01;
					end
				end
				ADCRO_GUARD: begin
					div <= 2'h0;
					if (rdy_sync[2] && rdy_sync[1]) begin
						state <= ADCRO_IDLE;
					end
				end
				default: begin
					state <= ADCRO_IDLE;
				end
			endcase
		end
	end

	assign lnk.shift_clock        = sclk;
	assign lnk.chain_in           = 1'b0;
	assign lnk.word_length_select = long_words;
	assign busy                   = (state != ADCRO_IDLE);
endmodule : adcro_host

// ---- hw/adcro_pkg.sv ----
// Shared constants for the converter result serial readout
// Function
// - Results use offset binary, monotonic code
// - Word length select high gives 20 bits
// - Select low drops four LSBs, 16 bits
// - Full scale saturates to all ones
// - Zero input gives code with bit 12
// - Negative beyond offset clips to zero
// - Latest result readable when ready falls
// - Serial out advances on shift clock fall
// - Ready falls on mclk, rises on shift
// - Host idles shift clock around toggle
// - Short words cut shift cycles by 20%
// - Own bits first, then chain bits
// - Chain input sampled on shift clock fall
// - Before-toggle readout ends before guard
// - After-toggle readout waits guard, ends early
// - Split readout pauses around toggle; host never splits, toggle waits until shifting ends
// - Non-continuous waits for second integration; here noncontinuous only mirrors period_short
// - Non-continuous keeps guards, ends before ready
// - Non-continuous when period below cycle time
package adcro_pkg;
	localparam int CHANNELS      = 8;
	localparam int WORD_LONG     = 20;
	localparam int WORD_SHORT    = 16;
	localparam int TRUNC_BITS    = 4;
	localparam int RAW_W         = 21;
	localparam logic [19:0] ZERO_CODE  = 20'h01000;
	localparam logic [19:0] FULL_CODE  = 20'hfffff;
	localparam int FRAME_LONG    = CHANNELS * WORD_LONG;
	localparam int FRAME_SHORT   = CHANNELS * WORD_SHORT;
	localparam int GUARD_US      = 10;
	localparam int MCLK_MHZ      = 200;
	localparam int GUARD_CYC     = GUARD_US * MCLK_MHZ;
	localparam int SHIFT_DIV     = 4;
	localparam int CNT_W         = 8;
endpackage : adcro_pkg

// ---- hw/adcro_if.sv ----
// Link between converter readout end and host end
`timescale 1ns/10ps
interface adcro_if;
	logic shift_clock;
	logic serial_out;
	logic chain_in;
	logic data_ready_n;
	logic integrate_side_toggle;
	logic word_length_select;
	modport device (
		input  shift_clock,
		output serial_out,
		input  chain_in,
		output data_ready_n,
		input  integrate_side_toggle,
		input  word_length_select
	);
	modport host (
		output shift_clock,
		input  serial_out,
		output chain_in,
		input  data_ready_n,
		output integrate_side_toggle,
		output word_length_select
	);
endinterface : adcro_if

// ---- hw/adcro_device.sv ----
// Device end: result formatting and serial shifter
`timescale 1ns/10ps
module adcro_device #(
	parameter int CHANNELS = adcro_pkg::CHANNELS,
	parameter int RAW_W    = adcro_pkg::RAW_W
) (
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	adcro_if.device                          lnk,
	input  wire logic [CHANNELS*RAW_W-1:0]   integrate_side_toggle_raw,
	input  wire logic                        integrate_side_toggle_done,
	input  wire logic                        period_short,
	output logic                             noncontinuous
);
	// --------------------------------------------------
	// Formatting in the master clock domain
	// --------------------------------------------------
	logic [CHANNELS*20-1:0] result;
	logic                   result_tgl;
	logic                   load_pend;
	logic [1:0]             ack_sync;
	logic                   ack_seen;

	// Raw is signed two's complement, LSB units, relative to zero input
	function automatic logic [19:0] fmt(input logic [RAW_W-1:0] raw);
		logic [RAW_W:0] s;
		s = {raw[RAW_W-1], raw} + (RAW_W+1)'(adcro_pkg::ZERO_CODE);
		if (s[RAW_W])
			fmt = 20'h00000;
		else if (s[RAW_W-1:0] > (RAW_W)'(adcro_pkg::FULL_CODE))
			fmt = adcro_pkg::FULL_CODE;
		else
			fmt = s[19:0];
	endfunction : fmt

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			result    <= '0;
			load_pend <= 1'b0;
		end else begin
			load_pend <= integrate_side_toggle_done;
			if (integrate_side_toggle_done) begin
				for (int c = 0; c < CHANNELS; c++) begin
					result[c*20 +: 20] <= fmt(integrate_side_toggle_raw[c*RAW_W +: RAW_W]);
				end
			end
		end
	end

	// Toggle announces a new result to the link domain
	always_ff @(negedge mclk or negedge resetn) begin
		if (!resetn) begin
			result_tgl <= 1'b0;
		end else if (load_pend) begin
			result_tgl <= ~result_tgl;
		end
	end

	// Mode follows period relative to cycle time
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			noncontinuous <= 1'b0;
		end else begin
			noncontinuous <= period_short;
		end
	end

	// --------------------------------------------------
	// Link domain on shift_clock falling edge
	// --------------------------------------------------
	logic                   tgl_seen;
	logic                   fresh;
	logic [CHANNELS*20-1:0] sreg;
	logic [CHANNELS*20-1:0] frame_long;
	logic [CHANNELS*20-1:0] frame_short;
	logic [CHANNELS*20-1:0] frame_word;
	logic                   ready;

	// Frame images; result reloads on any integrate_side_toggle_done, not gated by ready
	for (genvar c = 0; c < CHANNELS; c++) begin : g_word
		assign frame_long[(CHANNELS-1-c)*20 +: 20]  = result[c*20 +: 20];
		assign frame_short[(CHANNELS-1-c)*16 +: 16] = result[c*20+4 +: 16];
	end
	assign frame_short[CHANNELS*20-1:CHANNELS*16] = '0;
	assign frame_word = lnk.word_length_select ? frame_long : frame_short;
	assign fresh      = (result_tgl != tgl_seen);

	// Ready: set on new result, cleared two mclk falls after the first shift clock fall
	always_ff @(negedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_sync <= 2'h0;
			ack_seen <= 1'b0;
		end else begin
			ack_sync <= {ack_sync[0], tgl_seen};
			ack_seen <= ack_sync[1];
		end
	end

	assign ready = (result_tgl != ack_seen) && (ack_sync[1] == ack_seen);
	assign lnk.data_ready_n = ~ready;

	// First fall of a frame takes the image already shifted once
	always_ff @(negedge lnk.shift_clock or negedge resetn) begin
		if (!resetn) begin
			tgl_seen <= 1'b0;
			sreg     <= '0;
		end else if (fresh) begin
			tgl_seen <= result_tgl;
			sreg     <= {frame_word[CHANNELS*20-2:0], lnk.chain_in};
		end else begin
			sreg <= {sreg[CHANNELS*20-2:0], lnk.chain_in};
		end
	end

	// Own bits first, chain bits follow after the frame length
	always_comb begin
		if (lnk.word_length_select) begin
			lnk.serial_out = fresh ? frame_word[CHANNELS*20-1] : sreg[CHANNELS*20-1];
		end else begin
			lnk.serial_out = fresh ? frame_word[CHANNELS*16-1] : sreg[CHANNELS*16-1];
		end
	end
endmodule : adcro_device

// ---- bench/adcro_props.sv ----
// Checker on the link between the device and host ends
`timescale 1ns/10ps
module adcro_props #(
	parameter int GUARD_CYC = adcro_pkg::GUARD_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic shift_clock,
	input wire logic serial_out,
	input wire logic chain_in,
	input wire logic data_ready_n,
	input wire logic integrate_side_toggle,
	input wire logic word_length_select
);
	// ----------------------------------------
	// Ages of the last link events
	// ----------------------------------------
	int sc_age, tg_age, fall_age;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sc_age   <= GUARD_CYC;
			tg_age   <= GUARD_CYC;
			fall_age <= 255;
		end else begin
			sc_age   <= $changed(shift_clock) ? 0 : sc_age + (sc_age < 9999);
			tg_age   <= $changed(integrate_side_toggle) ? 0 : tg_age + (tg_age < 9999);
			fall_age <= $fell(shift_clock) ? 0 : fall_age + (fall_age < 255);
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	guard_before_a: assert property ($changed(integrate_side_toggle) |-> sc_age >= GUARD_CYC - 1)
		else $error("shift clock active before toggle");
	guard_after_a: assert property ($changed(shift_clock) |-> tg_age >= GUARD_CYC - 1)
		else $error("shift clock active after toggle");
	ready_hold_a: assert property ($fell(data_ready_n) |=> !data_ready_n [*8])
		else $error("ready released early");
	ready_idle_a: assert property ($fell(data_ready_n) |-> shift_clock)
		else $error("ready fell during shifting");
	ready_rise_a: assert property ($rose(data_ready_n) |-> fall_age < 16)
		else $error("ready rose without shift fall");
	clock_shape_a: assert property ($fell(shift_clock) |=> !shift_clock ##1 shift_clock)
		else $error("shift clock low phase wrong");
	toggle_quiet_a: assert property (!shift_clock |-> $stable(integrate_side_toggle))
		else $error("toggle moved while shifting");
	format_quiet_a: assert property (!shift_clock |-> $stable(word_length_select))
		else $error("word length moved while shifting");
endmodule : adcro_props

// ---- bench/adc_result_serial_readout_tb.sv ----
// Bench joining the device and host ends of the result readout
`timescale 1ns/10ps
module adc_result_serial_readout_tb;
	logic         mclk, resetn, integrate_side_toggle_done, period_short, toggle_req, long_words, t0;
	logic [167:0] integrate_side_toggle_raw;
	logic         bit_valid, bit_data, busy, noncontinuous;
	logic         exp_q[$];
	logic [20:0]  edge_v[4] = '{21'h000000, 21'h1fefff, 21'h1ff000, 21'h0fffff};
	int           num_errors, n_tests, nb, k;
	int           seed = 80308;
	adcro_if lnk();
	adcro_device adcro_device_i (.mclk(mclk), .resetn(resetn), .lnk(lnk), .integrate_side_toggle_raw(integrate_side_toggle_raw),
		.integrate_side_toggle_done(integrate_side_toggle_done), .period_short(period_short), .noncontinuous(noncontinuous));
	adcro_host #(.GUARD_CYC(20)) adcro_host_i (.mclk(mclk), .resetn(resetn), .lnk(lnk),
		.toggle_req(toggle_req), .long_words(long_words), .bit_valid(bit_valid),
		.bit_data(bit_data), .busy(busy));
	adcro_props #(.GUARD_CYC(20)) adcro_props_i (.mclk(mclk), .resetn(resetn),
		.shift_clock(lnk.shift_clock), .serial_out(lnk.serial_out), .chain_in(lnk.chain_in),
		.data_ready_n(lnk.data_ready_n), .integrate_side_toggle(lnk.integrate_side_toggle),
		.word_length_select(lnk.word_length_select));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task conclude;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task compare(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : compare
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	function automatic logic [19:0] code(input logic [20:0] raw);
		logic signed [22:0] v;
		v = $signed({raw[20], raw[20], raw}) + $signed({3'h0, adcro_pkg::ZERO_CODE});
		if (v < 0) return 20'h00000;
		if (v > 23'sh0fffff) return adcro_pkg::FULL_CODE;
		return v[19:0];
	endfunction : code
	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	always @(posedge mclk) begin
		if (bit_valid === 1'b1) begin
			nb++;
			compare(bit_data, exp_q.size() > 0 ? exp_q.pop_front() : 1'bx);
		end
	end
	task wait_done;
		int i;
		for (i = 0; i < 4000 && (exp_q.size() > 0 || busy !== 1'b0); i++) step(1);
		if (i == 4000) begin
			num_errors++;
			conclude();
		end
	endtask : wait_done
	task frame(input logic lw);
		int i, b;
		logic [31:0] r;
		logic [19:0] c;
		long_words = lw;
		nb = 0;
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			integrate_side_toggle_raw[i*21 +: 21] = (i < 4) ? edge_v[i] : r[20:0];
			c = code(integrate_side_toggle_raw[i*21 +: 21]);
			for (b = 19; b > (lw ? -1 : 3); b--) exp_q.push_back(c[b]);
		end
		integrate_side_toggle_done = 1'b1;
		step(1);
		integrate_side_toggle_done = 1'b0;
		wait_done();
		compare(nb, lw ? 160 : 128);
	endtask : frame
	initial begin
		{resetn, integrate_side_toggle_done, period_short, toggle_req, long_words} = 5'h00;
		integrate_side_toggle_raw = '0;
		step(16);
		resetn = 1'b1;
		step(3);
		period_short = 1'b1;
		step(3);
		compare(noncontinuous, 1'b1);
		period_short = 1'b0;
		step(3);
		compare(noncontinuous, 1'b0);
		frame(1'b1);
		step(25);
		t0 = lnk.integrate_side_toggle;
		toggle_req = 1'b1;
		for (k = 0; k < 100 && lnk.integrate_side_toggle === t0; k++) step(1);
		toggle_req = 1'b0;
		compare(lnk.integrate_side_toggle, {~t0});
		frame(1'b0);
		frame(1'b1);
		conclude();
	end
endmodule : adc_result_serial_readout_tb
